// >>> core/io_ctl_map.vh
`ifndef IO_CTL_MAP_VH
`define IO_CTL_MAP_VH

// shared control bus shape
`define NUM_CTL_LINES    12
`define NUM_DED_OE       6
`define NUM_GATE_SLOTS   6
`define NUM_BUS_OE       8
`define NUM_DED_PINS     6
`define NUM_DED_CLK      2
`define NUM_LOWSKEW      4
`define NUM_CLUSTERS     4

// gate slots and their alternate roles
`define SLOT_IO_BUS_CLOCK_0        0
`define SLOT_OE6         1
`define SLOT_IO_BUS_CLEAR_0        2
`define SLOT_OE7         3
`define SLOT_IO_BUS_CLEAR_1        4
`define SLOT_IO_BUS_CLOCK_1        5

// line source select codes (4 bits)
`define SRC_W            4
`define SRC_PIN_BASE     4'h0
`define SRC_CLU_BASE     4'h6
`define SRC_COLUMN       4'hA

// per-cell clock select (2 bits)
`define CLK_BUS0         2'h0
`define CLK_BUS1         2'h1
`define CLK_PIN0         2'h2
`define CLK_PIN1         2'h3

// per-cell clear select (2 bits)
`define CLR_NONE         2'h0
`define CLR_BUS0         2'h1
`define CLR_BUS1         2'h2

// per-cell gate / drive select (4 bits)
`define CKE_DIRECT       4'h6
`define CKE_ALWAYS       4'h7
`define OE_DIRECT        4'h8
`define OE_ALWAYS        4'h9

// routing channels
`define NUM_ROW_CELLS    4
`define NUM_COL_CELLS    2
`define NUM_CELLS        6
`define ROW_CHANNELS     144
`define ROW_PER_PIN      18
`define ROW_CELLS_SIDE   8
`define COL_CHANNELS     24
`define COL_PER_PIN      16
`define COL_CELL_STEP    8
`define DAT_SEL_W        5

`endif

// >>> core/pin_sync.v
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter W = 1
) (
  input  wire         mclk,
  input  wire         reset,
  input  wire [W-1:0] pin_in,
  output wire [W-1:0] level_out
);

  reg [W-1:0] s1_ff;
  reg [W-1:0] s2_ff;
  reg [W-1:0] s3_ff;
  reg [W-1:0] level_ff;

  assign level_out = level_ff;

  // a change counts only once stages two and three agree
  always @(posedge mclk) begin
    if (reset) begin
      s1_ff    <= {W{1'b0}};
      s2_ff    <= {W{1'b0}};
      s3_ff    <= {W{1'b0}};
      level_ff <= {W{1'b0}};
    end else begin
      s1_ff    <= pin_in;
      s2_ff    <= s1_ff;
      s3_ff    <= s2_ff;
      level_ff <= (s2_ff & s3_ff) | (level_ff & (s2_ff | s3_ff));
    end
  end

endmodule // pin_sync

`default_nettype wire

// >>> core/io_cell.v
`timescale 1ns/1ps
`default_nettype none

module io_cell (
  input  wire       mclk,
  input  wire       reset,
  input  wire       chip_rst,
  input  wire       clk_lvl,
  input  wire       cke,
  input  wire       clr,
  input  wire       oe,
  input  wire       out_mode,
  input  wire       reg_mode,
  input  wire       dat,
  input  wire       pin_in,
  output wire       q,
  output wire       pin_out,
  output wire       pin_oe,
  output wire [1:0] ch_drive
);

  reg       clk_prev_ff;
  reg       q_ff;
  reg       pin_out_ff;
  reg       pin_oe_ff;
  reg [1:0] ch_drive_ff;
  wire      clk_edge;

  assign clk_edge = clk_lvl & ~clk_prev_ff;
  assign q        = q_ff;
  assign pin_out  = pin_out_ff;
  assign pin_oe   = pin_oe_ff;
  assign ch_drive = ch_drive_ff;

  always @(posedge mclk) begin
    if (reset) begin
      clk_prev_ff <= 1'b0;
    end else begin
      clk_prev_ff <= clk_lvl;
    end
  end

  // clear is sampled, not truly async: one clock domain only
  always @(posedge mclk) begin
    if (reset || chip_rst) begin
      q_ff <= 1'b0;
    end else if (clr) begin
      q_ff <= 1'b0;
    end else if (clk_edge && cke) begin
      q_ff <= out_mode ? dat : pin_in;
    end
  end

  always @(posedge mclk) begin
    if (reset) begin
      pin_out_ff  <= 1'b0;
      pin_oe_ff   <= 1'b0;
      ch_drive_ff <= 2'h0;
    end else begin
      pin_out_ff  <= reg_mode ? q_ff : dat;
      pin_oe_ff   <= out_mode & oe;
      // input cell feeds two channels at once
      ch_drive_ff <= out_mode ? 2'h0 : {2{reg_mode ? q_ff : pin_in}};
    end
  end

endmodule // io_cell

`default_nettype wire

// >>> core/io_ctl_router.v
`timescale 1ns/1ps
`default_nettype none
`include "io_ctl_map.vh"

// Summary of operation
// - twelve shared lines; each cell picks controls
// - bus limits: eight OE, six CKE, two CLK/CLR
// - cells may take CKE/OE direct from logic
// - cells may clock from two dedicated pins
// - lines sourced from pins, clusters, column route
// - chip reset low clears every cell register
// - six OE lines; six gate slots with alternates
// - four bus lines may drive low-skew nets
// - internally driven net ignores its dedicated pin
// - chip output enable low tri-states all pins
// - input cell drives two row channels
// - row-end output takes one row channel
// - row mux reaches 18 of 144 channels
// - column-end cell drives two channels, muxes output
// - column cells reach channel sets eight apart that overlap in channels 8 to 15
// - column mux reaches 16 of 24 channels
module io_ctl_router (
  input  wire                                     mclk,
  input  wire                                     reset,
  input  wire [`NUM_DED_PINS-1:0]                 ded_pin,
  input  wire [`NUM_DED_CLK-1:0]                  ded_clk_pin,
  input  wire                                     chip_rst_n,
  input  wire                                     chip_oe_n,
  input  wire                                     chip_oe_feature,
  input  wire [`NUM_CTL_LINES*`NUM_CLUSTERS-1:0]  cluster_first_cell,
  input  wire [`NUM_CTL_LINES-1:0]                column_route,
  input  wire [`NUM_CTL_LINES*`SRC_W-1:0]         line_src_sel,
  input  wire [`NUM_GATE_SLOTS-1:0]               slot_alt,
  input  wire [`NUM_LOWSKEW-1:0]                  lowskew_internal,
  input  wire [`NUM_CELLS*2-1:0]                  cell_clk_sel,
  input  wire [`NUM_CELLS*2-1:0]                  cell_clr_sel,
  input  wire [`NUM_CELLS*4-1:0]                  cell_cke_sel,
  input  wire [`NUM_CELLS*4-1:0]                  cell_oe_sel,
  input  wire [`NUM_CELLS*`DAT_SEL_W-1:0]         cell_dat_sel,
  input  wire [`NUM_CELLS-1:0]                    cell_out_mode,
  input  wire [`NUM_CELLS-1:0]                    cell_reg_mode,
  input  wire [`NUM_CELLS-1:0]                    direct_cke,
  input  wire [`NUM_CELLS-1:0]                    direct_oe,
  input  wire [`ROW_CHANNELS-1:0]                 row_chan,
  input  wire [`COL_CHANNELS-1:0]                 col_chan,
  input  wire [`NUM_CELLS-1:0]                    io_pin_in,
  output wire [`NUM_CELLS-1:0]                    io_pin_out,
  output wire [`NUM_CELLS-1:0]                    io_pin_oe,
  output wire [`NUM_CELLS-1:0]                    io_reg_q,
  output wire [`NUM_ROW_CELLS*2-1:0]              row_drive,
  output wire [`NUM_COL_CELLS*2-1:0]              col_drive,
  output wire [`NUM_CTL_LINES-1:0]                ctl_bus,
  output wire [`NUM_LOWSKEW-1:0]                  lowskew_net,
  output wire [`NUM_LOWSKEW-1:0]                  ded_pin_unused
);

  // picks one bit of a vector by index, out of range gives zero
  function pick_bit;
    input [255:0] vec;
    input [7:0]   idx;
    begin
      pick_bit = vec[idx];
    end
  endfunction

  wire [`NUM_DED_PINS-1:0]   ded_pin_s;
  wire [`NUM_DED_CLK-1:0]    ded_clk_s;
  wire [1:0]                 chip_ctl_s;
  wire [`NUM_CELLS-1:0]      io_pin_s;
  wire                       chip_rst;
  wire                       chip_oe_s;

  pin_sync #(
    .W(`NUM_DED_PINS)
  ) u_sync_ded (
    .mclk      (mclk),
    .reset     (reset),
    .pin_in    (ded_pin),
    .level_out (ded_pin_s)
  );

  pin_sync #(
    .W(`NUM_DED_CLK)
  ) u_sync_clk (
    .mclk      (mclk),
    .reset     (reset),
    .pin_in    (ded_clk_pin),
    .level_out (ded_clk_s)
  );

  // active-low pins inverted ahead of the sync: its cleared state then reads as idle
  pin_sync #(
    .W(2)
  ) u_sync_chip (
    .mclk      (mclk),
    .reset     (reset),
    .pin_in    ({~chip_oe_n, ~chip_rst_n}),
    .level_out (chip_ctl_s)
  );

  pin_sync #(
    .W(`NUM_CELLS)
  ) u_sync_io (
    .mclk      (mclk),
    .reset     (reset),
    .pin_in    (io_pin_in),
    .level_out (io_pin_s)
  );

  assign chip_rst  = chip_ctl_s[0] & ~reset;
  assign chip_oe_s = chip_ctl_s[1];

  // shared control lines
  reg  [`NUM_CTL_LINES-1:0] ctl_ff;
  assign ctl_bus = ctl_ff;

  genvar li;
  generate
    for (li = 0; li < `NUM_CTL_LINES; li = li + 1) begin : g_line
      wire [`SRC_W-1:0]        src;
      wire [`NUM_CLUSTERS-1:0] clu;
      reg                      nxt_line;
      assign src = line_src_sel[li*`SRC_W +: `SRC_W];
      assign clu = cluster_first_cell[li*`NUM_CLUSTERS +: `NUM_CLUSTERS];
      always @* begin
        if (src < `SRC_CLU_BASE) begin
          nxt_line = pick_bit({250'h0, ded_pin_s}, {4'h0, src});
        end else if (src < `SRC_COLUMN) begin
          nxt_line = pick_bit({252'h0, clu}, {4'h0, src - `SRC_CLU_BASE});
        end else if (src == `SRC_COLUMN) begin
          nxt_line = column_route[li];
        end else begin
          nxt_line = 1'b0;
        end
      end
      always @(posedge mclk) begin
        if (reset) begin
          ctl_ff[li] <= 1'b0;
        end else begin
          ctl_ff[li] <= nxt_line;
        end
      end
    end
  endgenerate

  // line roles: 0..5 dedicated drive, 6..11 gate slots
  wire [`NUM_GATE_SLOTS-1:0] slot_line;
  assign slot_line = ctl_ff[`NUM_CTL_LINES-1:`NUM_DED_OE];

  wire [`NUM_BUS_OE-1:0]     bus_oe;
  wire [`NUM_GATE_SLOTS-1:0] io_clk_gate;
  wire                       io_bus_clock_0;
  wire                       io_bus_clock_1;
  wire                       io_bus_clear_0;
  wire                       io_bus_clear_1;
  wire                       pin_drive_ctl_6;
  wire                       pin_drive_ctl_7;

  // a slot serves as gate or as its alternate, never both
  assign io_clk_gate     = slot_line & ~slot_alt;
  assign io_bus_clock_0  = slot_line[`SLOT_IO_BUS_CLOCK_0] & slot_alt[`SLOT_IO_BUS_CLOCK_0];
  assign io_bus_clock_1  = slot_line[`SLOT_IO_BUS_CLOCK_1] & slot_alt[`SLOT_IO_BUS_CLOCK_1];
  assign io_bus_clear_0  = slot_line[`SLOT_IO_BUS_CLEAR_0] & slot_alt[`SLOT_IO_BUS_CLEAR_0];
  assign io_bus_clear_1  = slot_line[`SLOT_IO_BUS_CLEAR_1] & slot_alt[`SLOT_IO_BUS_CLEAR_1];
  assign pin_drive_ctl_6 = slot_line[`SLOT_OE6] & slot_alt[`SLOT_OE6];
  assign pin_drive_ctl_7 = slot_line[`SLOT_OE7] & slot_alt[`SLOT_OE7];
  assign bus_oe = {pin_drive_ctl_7, pin_drive_ctl_6, ctl_ff[`NUM_DED_OE-1:0]};

  // low-skew nets
  reg  [`NUM_LOWSKEW-1:0] lowskew_ff;
  wire [`NUM_LOWSKEW-1:0] bus_global;
  wire                    lowskew_net_0;
  wire                    lowskew_net_3;

  assign bus_global = {slot_line[`SLOT_IO_BUS_CLOCK_1], slot_line[`SLOT_OE7],
                       slot_line[`SLOT_OE6], slot_line[`SLOT_IO_BUS_CLOCK_0]};
  assign lowskew_net    = lowskew_ff;
  assign lowskew_net_0  = lowskew_ff[0];
  assign lowskew_net_3  = lowskew_ff[3];
  // pin left unused whenever logic owns the net
  assign ded_pin_unused = lowskew_internal;

  always @(posedge mclk) begin
    if (reset) begin
      lowskew_ff <= {`NUM_LOWSKEW{1'b0}};
    end else begin
      lowskew_ff <= (bus_global & lowskew_internal) |
                    (ded_pin_s[`NUM_LOWSKEW-1:0] & ~lowskew_internal);
    end
  end

  // io cells
  wire [`NUM_CELLS-1:0]   cell_pin_oe;
  wire [`NUM_CELLS*2-1:0] cell_ch;
  reg                     oe_kill_ff;

  always @(posedge mclk) begin
    if (reset) begin
      oe_kill_ff <= 1'b0;
    end else begin
      oe_kill_ff <= chip_oe_feature & chip_oe_s;
    end
  end

  // global drive-off overrides every cell enable
  assign io_pin_oe = cell_pin_oe & {`NUM_CELLS{~oe_kill_ff}};
  assign row_drive = cell_ch[`NUM_ROW_CELLS*2-1:0];
  assign col_drive = cell_ch[`NUM_CELLS*2-1:`NUM_ROW_CELLS*2];

  genvar ci;
  generate
    for (ci = 0; ci < `NUM_CELLS; ci = ci + 1) begin : g_cell
      wire [1:0]            clk_sel;
      wire [1:0]            clr_sel;
      wire [3:0]            cke_sel;
      wire [3:0]            oe_sel;
      wire [`DAT_SEL_W-1:0] dsel;
      wire [31:0]           cell_base;
      wire [7:0]            row_idx;
      wire [7:0]            col_idx;
      reg                   clk_lvl;
      reg                   clr;
      reg                   cke;
      reg                   oe;
      reg                   dat;
      assign clk_sel = cell_clk_sel[ci*2 +: 2];
      assign clr_sel = cell_clr_sel[ci*2 +: 2];
      assign cke_sel = cell_cke_sel[ci*4 +: 4];
      assign oe_sel  = cell_oe_sel[ci*4 +: 4];
      assign dsel    = cell_dat_sel[ci*`DAT_SEL_W +: `DAT_SEL_W];
      assign cell_base = (ci < `NUM_ROW_CELLS) ? ci : (ci - `NUM_ROW_CELLS) * `COL_CELL_STEP;
      // eight cells a side: the row step is a shift by three
      assign row_idx   = {dsel, 3'h0} + cell_base[7:0];
      assign col_idx   = {3'h0, dsel} + cell_base[7:0];

      always @* begin
        case (clk_sel)
          `CLK_BUS0: clk_lvl = io_bus_clock_0;
          `CLK_BUS1: clk_lvl = io_bus_clock_1;
          `CLK_PIN0: clk_lvl = ded_clk_s[0];
          default:   clk_lvl = ded_clk_s[1];
        endcase
        case (clr_sel)
          `CLR_BUS0: clr = io_bus_clear_0;
          `CLR_BUS1: clr = io_bus_clear_1;
          default:   clr = 1'b0;
        endcase
        if (cke_sel < `CKE_DIRECT) begin
          cke = pick_bit({250'h0, io_clk_gate}, {4'h0, cke_sel});
        end else if (cke_sel == `CKE_DIRECT) begin
          cke = direct_cke[ci];
        end else if (cke_sel == `CKE_ALWAYS) begin
          cke = 1'b1;
        end else begin
          cke = 1'b0;
        end
        if (oe_sel < `OE_DIRECT) begin
          oe = pick_bit({248'h0, bus_oe}, {4'h0, oe_sel});
        end else if (oe_sel == `OE_DIRECT) begin
          oe = direct_oe[ci];
        end else if (oe_sel == `OE_ALWAYS) begin
          oe = 1'b1;
        end else begin
          oe = 1'b0;
        end
        if (ci < `NUM_ROW_CELLS) begin
          // row cell k sees channels k, k+8, ... k+136
          if (dsel < `ROW_PER_PIN) begin
            dat = pick_bit({112'h0, row_chan}, row_idx);
          end else begin
            dat = 1'b0;
          end
        end else begin
          // column cells see windows shifted by eight
          if (dsel < `COL_PER_PIN) begin
            dat = pick_bit({232'h0, col_chan}, col_idx);
          end else begin
            dat = 1'b0;
          end
        end
      end

      io_cell u_cell (
        .mclk     (mclk),
        .reset    (reset),
        .chip_rst (chip_rst),
        .clk_lvl  (clk_lvl),
        .cke      (cke),
        .clr      (clr),
        .oe       (oe),
        .out_mode (cell_out_mode[ci]),
        .reg_mode (cell_reg_mode[ci]),
        .dat      (dat),
        .pin_in   (io_pin_s[ci]),
        .q        (io_reg_q[ci]),
        .pin_out  (io_pin_out[ci]),
        .pin_oe   (cell_pin_oe[ci]),
        .ch_drive (cell_ch[ci*2 +: 2])
      );
    end
  endgenerate

endmodule // io_ctl_router

`default_nettype wire

// >>> testbench/io_ctl_router_chk.sv
`timescale 1ns/1ps
`default_nettype none
module io_ctl_router_chk (
  input wire logic         mclk,
  input wire logic         reset,
  input wire logic [47:0]  line_src_sel,
  input wire logic [47:0]  cluster_first_cell,
  input wire logic [11:0]  column_route,
  input wire logic [11:0]  ctl_bus,
  input wire logic [3:0]   lowskew_internal,
  input wire logic [3:0]   lowskew_net,
  input wire logic [3:0]   ded_pin_unused,
  input wire logic [5:0]   cell_out_mode,
  input wire logic [7:0]   row_drive,
  input wire logic         chip_rst_n,
  input wire logic [5:0]   io_reg_q,
  input wire logic         chip_oe_feature,
  input wire logic         chip_oe_n,
  input wire logic [5:0]   io_pin_oe,
  input wire logic [29:0]  cell_dat_sel,
  input wire logic [5:0]   cell_reg_mode,
  input wire logic [143:0] row_chan,
  input wire logic [5:0]   io_pin_out
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // outputs may still hold reset values at the first edge after release
  a_bus_cluster: assert property (!$past(reset) && $past(line_src_sel[3:0]) == 4'h7
    |-> ctl_bus[0] == $past(cluster_first_cell[1])) else $error("line 0 not from cluster 1");
  a_bus_column: assert property (!$past(reset) && $past(line_src_sel[47:44]) == 4'hA
    |-> ctl_bus[11] == $past(column_route[11])) else $error("line 11 not from column route");
  a_lowskew_line: assert property (!$past(reset) && $past(lowskew_internal[0])
    |-> lowskew_net[0] == $past(ctl_bus[6])) else $error("low-skew net 0 not from line 6");
  a_pin_unused: assert property (ded_pin_unused == lowskew_internal)
    else $error("unused pin flags wrong");
  a_row_quiet: assert property (!$past(reset) && $past(cell_out_mode[0])
    |-> row_drive[1:0] == 2'b00) else $error("output cell drives row");
  a_row_copies: assert property (row_drive[6] == row_drive[7])
    else $error("row copies differ");
  a_chip_rst: assert property (!chip_rst_n [*8] |-> io_reg_q == 6'h00)
    else $error("register not held by chip reset");
  a_oe_kill: assert property ((chip_oe_feature && !chip_oe_n) [*8] |-> io_pin_oe == 6'h00)
    else $error("pins not released");
  a_row_mux: assert property (!$past(reset) && $past(cell_dat_sel[4:0]) == 5'h01
    && !$past(cell_reg_mode[0]) |-> io_pin_out[0] == $past(row_chan[8])) else $error("row mux pick wrong");
  c_column: cover property ($past(line_src_sel[47:44]) == 4'hA && ctl_bus[11]);
  c_chip_rst: cover property (!chip_rst_n [*8]);
  c_oe_kill: cover property ((chip_oe_feature && !chip_oe_n) [*8]);
endmodule // io_ctl_router_chk
bind io_ctl_router io_ctl_router_chk chk_u (.mclk(mclk), .reset(reset), .line_src_sel(line_src_sel),
  .cluster_first_cell(cluster_first_cell), .column_route(column_route), .ctl_bus(ctl_bus),
  .lowskew_internal(lowskew_internal), .lowskew_net(lowskew_net), .ded_pin_unused(ded_pin_unused),
  .cell_out_mode(cell_out_mode), .row_drive(row_drive), .chip_rst_n(chip_rst_n), .io_reg_q(io_reg_q),
  .chip_oe_feature(chip_oe_feature), .chip_oe_n(chip_oe_n), .io_pin_oe(io_pin_oe), .cell_dat_sel(cell_dat_sel),
  .cell_reg_mode(cell_reg_mode), .row_chan(row_chan), .io_pin_out(io_pin_out));
`default_nettype wire

// >>> testbench/far_logic.sv
`timescale 1ns/1ps
`default_nettype none
module far_logic (
  input  wire logic         mclk,
  input  wire logic         hold,
  input  wire logic [31:0]  rnd,
  input  wire logic [3:0]   lowskew_internal,
  output wire logic [143:0] row_chan,
  output wire logic [23:0]  col_chan,
  output wire logic [47:0]  cluster_first_cell,
  output wire logic [11:0]  column_route,
  output wire logic [5:0]   direct_cke,
  output wire logic [5:0]   direct_oe,
  output wire logic [5:0]   ded_pin
);
  // hold freezes the logic side: slow pin synchronisers need stable sources
  logic [31:0] w = 32'h0000_0000;
  always @(posedge mclk) begin
    if (!hold) begin
      w <= rnd;
    end
  end
  assign row_chan = {w, ~w, w ^ 32'hA5C3_0F96, ~w, w[15:0]};
  assign col_chan = {~w[7:0], w[31:16]};
  assign cluster_first_cell = {w[15:0], ~w};
  assign column_route = w[11:0];
  assign direct_cke = w[21:16];
  assign direct_oe = w[27:22];
  // pin behind an internally driven net held low, never floating
  assign ded_pin = w[31:26] & ~{2'b00, lowskew_internal};
endmodule // far_logic
`default_nettype wire

// >>> testbench/io_ctl_router_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin mismatches++; \
  $display("mismatch %s exp %0h got %0h", nm, ex, got); end end
module io_ctl_router_tb;
  logic         mclk = 1'b0;
  logic         reset = 1'b1;
  logic [1:0]   ded_clk_pin = 2'h0;
  logic         chip_rst_n = 1'b1;
  logic         chip_oe_n = 1'b1;
  logic         chip_oe_feature = 1'b0;
  logic [47:0]  line_src_sel = 48'h0;
  logic [5:0]   slot_alt = 6'h00;
  logic [3:0]   lowskew_internal = 4'h0;
  logic [11:0]  cell_clk_sel = 12'h000;
  logic [11:0]  cell_clr_sel = 12'h000;
  logic [23:0]  cell_cke_sel = 24'h777777;
  logic [23:0]  cell_oe_sel = 24'h999999;
  logic [29:0]  cell_dat_sel = 30'h0;
  logic [5:0]   cell_out_mode = 6'h3F;
  logic [5:0]   cell_reg_mode = 6'h00;
  logic [5:0]   io_pin_in = 6'h00;
  logic         hold = 1'b0;
  logic [31:0]  rnd = 32'h0;
  integer       seed = 32'h65243ED7;
  int           mismatches = 0;
  int           n_checks = 0;
  int           cyc = 0;
  int           i, k;
  logic [11:0]  eb;
  logic [5:0]   e6, old;
  wire [143:0]  row_chan;
  wire [23:0]   col_chan;
  wire [47:0]   cluster_first_cell;
  wire [11:0]   column_route, ctl_bus;
  wire [5:0]    direct_cke, direct_oe, ded_pin, io_pin_out, io_pin_oe, io_reg_q;
  wire [7:0]    row_drive;
  wire [3:0]    col_drive, lowskew_net, ded_pin_unused;

  io_ctl_router dut_u (.*);
  far_logic far_u (.*);

  function automatic logic src_val(input logic [3:0] c, input int ln);
    if (c < 4'h6) return ded_pin[c];
    if (c < 4'hA) return cluster_first_cell[4*ln+c-6];
    return (c == 4'hA) ? column_route[ln] : 1'b0;
  endfunction
  function automatic logic dat_exp(input int cl, input logic [4:0] s);
    if (cl < 4) return (s < 5'd18) ? row_chan[s*8+cl] : 1'b0;
    return (s < 5'd16) ? col_chan[s+8*(cl-4)] : 1'b0;
  endfunction
  // every line sources the column route here
  function automatic logic oe_exp(input logic [3:0] c, input int cl);
    case (c)
      4'h6: return slot_alt[1] & column_route[7];
      4'h7: return slot_alt[3] & column_route[9];
      4'h8: return direct_oe[cl];
      4'h9: return 1'b1;
      default: return (c < 4'h6) ? column_route[c] : 1'b0;
    endcase
  endfunction

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // new logic-side values for one edge, then frozen while syncs settle
  task automatic roll(input logic [31:0] v, input int n);
    @(posedge mclk);
    hold <= 1'b0;
    rnd <= v;
    @(posedge mclk);
    hold <= 1'b1;
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask
  task automatic clk_pulse;
    @(posedge mclk);
    ded_clk_pin <= 2'b11;
    repeat (6) @(posedge mclk);
    ded_clk_pin <= 2'b00;
    repeat (6) @(posedge mclk);
    @(negedge mclk);
  endtask

  initial forever #5 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      mismatches++;
      complete_run;
    end
  end

  initial begin
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    for (k = 0; k < 12; k++) begin
      @(posedge mclk);
      line_src_sel <= {12{k[3:0]}};
      lowskew_internal <= 4'($random(seed));
      roll($random(seed), 8);
      for (i = 0; i < 12; i++) eb[i] = src_val(k[3:0], i);
      `CHK("ctl_bus", eb, ctl_bus)
      for (i = 0; i < 4; i++) e6[i] = lowskew_internal[i] ? eb[6 + i + (i > 1) + (i > 2)] : ded_pin[i];
      `CHK("lowskew_net", e6[3:0], lowskew_net)
      `CHK("ded_pin_unused", lowskew_internal, ded_pin_unused)
    end
    @(posedge mclk);
    cell_clk_sel <= 12'h00E;
    cell_reg_mode <= 6'h3F;
    old = 6'h00;
    for (k = 0; k < 8; k++) begin
      @(posedge mclk);
      cell_cke_sel <= (k == 0) ? 24'h777777 : 24'h666666;
      roll($random(seed), 2);
      clk_pulse;
      e6 = old;
      for (i = 0; i < 2; i++) if (k == 0 || direct_cke[i]) e6[i] = row_chan[i];
      `CHK("io_reg_q", e6[1:0], io_reg_q[1:0])
      `CHK("io_pin_out", e6[1:0], io_pin_out[1:0])
      old = e6;
    end
    @(posedge mclk);
    cell_cke_sel <= 24'h777777;
    cell_clr_sel <= 12'h001;
    line_src_sel <= {12{4'hA}};
    slot_alt <= 6'h04;
    roll(32'h0000_0101, 8);
    clk_pulse;
    `CHK("clear wins", 1'b0, io_reg_q[0])
    @(posedge mclk);
    slot_alt <= 6'h00;
    clk_pulse;
    `CHK("clear unused", 1'b1, io_reg_q[0])
    @(posedge mclk);
    chip_rst_n <= 1'b0;
    clk_pulse;
    `CHK("chip reset", 6'h00, io_reg_q)
    @(posedge mclk);
    chip_rst_n <= 1'b1;
    cell_clk_sel <= 12'h001;
    cell_cke_sel <= 24'h222222;
    slot_alt <= 6'h21;
    // cell 0 clocked by slot 5 line, gated by slot 2 line; cell 1 on slot 0 line, never rising
    for (k = 0; k < 4; k++) begin
      roll((k == 1) ? 32'h0000_0901 : (k == 2) ? 32'h0000_0001 : (k == 3) ? 32'h0000_0800 : 32'h0, 8);
      `CHK("bus clock", {1'b0, k != 0}, io_reg_q[1:0])
    end
    @(posedge mclk);
    slot_alt <= 6'h0A;
    for (k = 0; k < 12; k++) begin
      @(posedge mclk);
      cell_oe_sel <= {6{k[3:0]}};
      roll($random(seed), 8);
      for (i = 0; i < 6; i++) e6[i] = oe_exp(k[3:0], i);
      `CHK("io_pin_oe", e6, io_pin_oe)
    end
    @(posedge mclk);
    chip_oe_n <= 1'b0;
    cell_oe_sel <= 24'h999999;
    roll($random(seed), 8);
    `CHK("oe feature off", 6'h3F, io_pin_oe)
    @(posedge mclk);
    chip_oe_feature <= 1'b1;
    roll($random(seed), 8);
    `CHK("oe kill", 6'h00, io_pin_oe)
    @(posedge mclk);
    chip_oe_n <= 1'b1;
    chip_oe_feature <= 1'b0;
    cell_reg_mode <= 6'h00;
    for (k = 0; k < 16; k++) begin
      @(posedge mclk);
      cell_dat_sel <= (k == 0) ? {6{5'd17}} : (k == 1) ? {6{5'd15}} : (k == 2) ? {6{5'd1}} : 30'($random(seed));
      roll($random(seed), 4);
      for (i = 0; i < 6; i++) e6[i] = dat_exp(i, cell_dat_sel[5*i+:5]);
      `CHK("io_pin_out", e6, io_pin_out)
    end
    @(posedge mclk);
    cell_out_mode <= 6'h00;
    for (k = 0; k < 8; k++) begin
      @(posedge mclk);
      io_pin_in <= 6'($random(seed));
      roll($random(seed), 8);
      for (i = 0; i < 4; i++) eb[2*i+:2] = {2{io_pin_in[i]}};
      e6 = {2'b00, {2{io_pin_in[5]}}, {2{io_pin_in[4]}}};
      `CHK("row_drive", eb[7:0], row_drive)
      `CHK("col_drive", e6[3:0], col_drive)
    end
    complete_run;
  end
endmodule // io_ctl_router_tb
`default_nettype wire
